//--- rtl/ebc_top.sv
// External bus control, chip selects and mode selection
`timescale 1ns/1ps
module ebc_top
    import ebc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_link_clk,
    input wire logic i_strap_a,
    input wire logic i_strap_b,
    input wire logic i_strap_c,
    input wire logic i_internal_flash_enable,
    input wire logic i_secure,
    input wire logic i_mode_wr,
    input wire logic [2:0] i_mode_wdata,
    output logic [2:0] o_mode,
    output logic o_expanded,
    output logic o_narrow,
    input wire logic i_dbg_enable,
    input wire logic i_dbg_activate,
    input wire logic i_dbg_exit,
    output logic o_bdm_active,
    input wire logic i_page_expand_enable,
    input wire logic i_stretch_enable,
    input wire logic i_int_visibility,
    input wire logic i_bus_clock_out_disable,
    input wire logic i_direction_pin_enable,
    input wire logic i_byte_strobe_pin_enable,
    input wire logic [1:0] i_xport_gpio_out,
    input wire logic [1:0] i_xport_gpio_oe,
    input wire logic [1:0] i_strap_pins_out,
    output logic [1:0] o_strap_pins_out,
    output logic o_strap_pins_oe,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic i_req_write,
    input wire logic i_req_wide,
    input wire logic [15:0] i_req_addr,
    output logic o_req_done,
    output logic o_rw,
    output logic o_rw_oe,
    output logic o_low_byte_strobe_n,
    output logic o_low_byte_strobe_oe,
    output logic o_addr_bit0,
    output logic o_bus_clock_out,
    output logic [1:0] o_xport_out,
    output logic [1:0] o_xport_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Core domain: straps, mode and request capture

    logic [4:0] core_s;
    logic [2:0] strap_s;
    logic flash_en_s;
    logic done_s;
    logic [2:0] mode_q;
    logic expanded;
    logic narrow;
    logic special;
    logic bdm_en_q;
    logic bdm_q;
    logic busy_q;
    logic done_seen_q;
    logic req_tgl_q;
    logic [15:0] rq_addr_q;
    logic rq_wr_q;
    logic rq_wide_q;
    logic rq_split_q;
    logic rq_ecs_q;
    logic rq_xcs_q;
    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] cfg_d;
    logic strap_oe_q;
    logic [1:0] strap_out_q;
    logic done_tgl_q;

    // Pins and the link done toggle cross into the core clock
    ebc_sync #(.WIDTH(5)) u_core_sync (
        .i_clk(i_core_clk),
        .i_d({done_tgl_q, i_strap_c, i_strap_b, i_strap_a, i_internal_flash_enable}),
        .o_q(core_s)
    );

    assign done_s = core_s[4];
    assign strap_s = core_s[3:1];
    assign flash_en_s = core_s[0];

    ebc_mode_dec u_mode_dec (
        .i_mode(mode_q),
        .o_expanded(expanded),
        .o_narrow(narrow),
        .o_special_single(special)
    );

    // Mode taken from straps while reset is held, later writable unless secure
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            mode_q <= strap_s;
        end else if (i_mode_wr && !i_secure) begin
            mode_q <= i_mode_wdata;
        end
    end

    // Debug state: halted out of special single chip, else needs commands
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            bdm_en_q <= (strap_s == MODE_SPEC_SINGLE);
            bdm_q <= (strap_s == MODE_SPEC_SINGLE);
        end else begin
            bdm_en_q <= bdm_en_q | i_dbg_enable;
            if (i_dbg_activate && bdm_en_q) begin
                bdm_q <= 1'h1;
            end else if (i_dbg_exit) begin
                bdm_q <= 1'h0;
            end
        end
    end

    // Address space decode for the chip selects
    logic in_regs;
    logic in_ram;
    logic in_flash;
    logic flash_mapped;
    logic cs_role;
    logic sel_ecs;
    logic sel_xcs;
    logic accept;
    assign in_regs = (i_req_addr <= REG_LAST);
    assign in_ram = (i_req_addr >= RAM_BASE) && (i_req_addr <= RAM_LAST);
    assign in_flash = (i_req_addr >= FLASH_BASE);
    assign flash_mapped = !expanded || flash_en_s;
    assign cs_role = expanded && i_page_expand_enable;
    assign sel_ecs = cs_role && in_flash && !flash_mapped;
    assign sel_xcs = cs_role && !sel_ecs && !in_regs && !in_ram &&
                     !(in_flash && flash_mapped);
    assign accept = i_req_valid && o_req_ready;
    assign o_req_ready = !busy_q && expanded;
    assign o_req_done = done_s ^ done_seen_q;

    // Request fields stay still while the toggle crosses
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            busy_q <= 1'h0;
            done_seen_q <= 1'h0;
            req_tgl_q <= 1'h0;
            rq_addr_q <= 16'h0000;
            rq_wr_q <= 1'h0;
            rq_wide_q <= 1'h0;
            rq_split_q <= 1'h0;
            rq_ecs_q <= 1'h0;
            rq_xcs_q <= 1'h0;
        end else begin
            done_seen_q <= done_s;
            if (accept) begin
                busy_q <= 1'h1;
                req_tgl_q <= !req_tgl_q;
                rq_addr_q <= i_req_addr;
                rq_wr_q <= i_req_write;
                rq_wide_q <= i_req_wide && !narrow;
                rq_split_q <= i_req_wide && narrow;
                rq_ecs_q <= sel_ecs;
                rq_xcs_q <= sel_xcs;
            end else if (o_req_done) begin
                busy_q <= 1'h0;
            end
        end
    end

    // Configuration levels, registered before they cross
    assign cfg_d[CFG_STR] = i_stretch_enable;
    assign cfg_d[CFG_IVIS] = i_int_visibility;
    assign cfg_d[CFG_BUS_CLOCK_OUT_DIS] = i_bus_clock_out_disable;
    assign cfg_d[CFG_DIRECTION_PIN_ENABLE] = i_direction_pin_enable && expanded;
    assign cfg_d[CFG_BYTE_STROBE_PIN_ENABLE] = i_byte_strobe_pin_enable && expanded;
    assign cfg_d[CFG_CS_ROLE] = cs_role;
    assign cfg_d[CFG_GPIO_OUT+1:CFG_GPIO_OUT] = i_xport_gpio_out;
    assign cfg_d[CFG_GPIO_OE+1:CFG_GPIO_OE] = i_xport_gpio_oe;

    // Strap pins become outputs once an expanded mode is running
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cfg_q <= '0;
            strap_oe_q <= 1'h0;
            strap_out_q <= 2'h0;
        end else begin
            cfg_q <= cfg_d;
            strap_oe_q <= expanded;
            strap_out_q <= i_strap_pins_out;
        end
    end

    assign o_mode = mode_q;
    assign o_expanded = expanded;
    assign o_narrow = narrow;
    assign o_bdm_active = bdm_q;
    assign o_strap_pins_oe = strap_oe_q;
    assign o_strap_pins_out = strap_out_q;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: bus cycle sequencer and pins

    logic [1:0] lnk_s;
    logic lrst;
    logic req_s;
    logic [CFG_W-1:0] cfg_s;
    ebc_link_e st_q;
    logic [1:0] ph_q;
    logic req_seen_q;
    logic first_q;
    logic cap_wr_q;
    logic cap_wide_q;
    logic cap_split_q;
    logic cap_ecs_q;
    logic cap_xcs_q;
    logic rw_q;
    logic low_byte_strobe_q;
    logic a0_q;
    logic bus_clock_out_q;
    logic rw_oe_q;
    logic low_byte_strobe_oe_q;
    logic [1:0] xport_out_q;
    logic [1:0] xport_oe_q;

    // Reset and request toggle reach the link clock
    ebc_sync #(.WIDTH(2)) u_link_sync (
        .i_clk(i_link_clk),
        .i_d({i_srst, req_tgl_q}),
        .o_q(lnk_s)
    );

    ebc_sync #(.WIDTH(CFG_W)) u_cfg_sync (
        .i_clk(i_link_clk),
        .i_d(cfg_q),
        .o_q(cfg_s)
    );

    assign lrst = lnk_s[1];
    assign req_s = lnk_s[0];

    // Sequencer decode
    logic new_req;
    logic start;
    logic active;
    logic gap;
    logic cyc_end;
    logic second;
    logic ecs_n_d;
    logic xcs_n_d;
    logic bus_clock_out_run;
    logic str_s;
    logic cs_role_s;
    assign new_req = req_s ^ req_seen_q;
    assign start = (st_q == EBC_L_IDLE) && new_req && (ph_q == PHASE_LAST);
    assign active = (st_q == EBC_L_CYC);
    assign cyc_end = active && (ph_q == PHASE_LAST);
    assign second = cyc_end && cap_split_q && first_q;
    assign str_s = cfg_s[CFG_STR];
    assign cs_role_s = cfg_s[CFG_CS_ROLE];
    assign gap = str_s && (ph_q == PHASE_GAP);
    assign ecs_n_d = !(active && cap_ecs_q && !gap);
    assign xcs_n_d = !(active && cap_xcs_q && !gap);
    assign bus_clock_out_run = !cfg_s[CFG_BUS_CLOCK_OUT_DIS] &&
                      (cfg_s[CFG_IVIS] || !str_s || (st_q != EBC_L_IDLE));

    // Phase counter gives four link clocks per bus cycle
    always_ff @(posedge i_link_clk) begin
        if (lrst) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // Access state machine
    always_ff @(posedge i_link_clk) begin
        if (lrst) begin
            st_q <= EBC_L_IDLE;
            req_seen_q <= 1'h0;
            done_tgl_q <= 1'h0;
            first_q <= 1'h0;
        end else begin
            unique case (st_q)
                EBC_L_IDLE: begin
                    if (start) begin
                        st_q <= EBC_L_CYC;
                        req_seen_q <= req_s;
                        first_q <= 1'h1;
                    end
                end
                EBC_L_CYC: begin
                    if (second) begin
                        first_q <= 1'h0;
                    end else if (cyc_end) begin
                        st_q <= EBC_L_DONE;
                    end
                end
                EBC_L_DONE: begin
                    done_tgl_q <= !done_tgl_q;
                    st_q <= EBC_L_IDLE;
                end
                default: begin
                    st_q <= EBC_L_IDLE;
                end
            endcase
        end
    end

    // Access fields caught at the start of the transfer
    always_ff @(posedge i_link_clk) begin
        if (lrst) begin
            cap_wr_q <= 1'h0;
            cap_wide_q <= 1'h0;
            cap_split_q <= 1'h0;
            cap_ecs_q <= 1'h0;
            cap_xcs_q <= 1'h0;
        end else if (start) begin
            cap_wr_q <= rq_wr_q;
            cap_wide_q <= rq_wide_q;
            cap_split_q <= rq_split_q;
            cap_ecs_q <= rq_ecs_q;
            cap_xcs_q <= rq_xcs_q;
        end
    end

    // Direction changes only at a start, so writes keep it low
    always_ff @(posedge i_link_clk) begin
        if (lrst) begin
            rw_q <= PIN_HIGH;
        end else if (start) begin
            rw_q <= !rq_wr_q;
        end
    end

    // Byte strobe and address bit 0 encode the access size
    always_ff @(posedge i_link_clk) begin
        if (lrst) begin
            low_byte_strobe_q <= PIN_HIGH;
            a0_q <= 1'h0;
        end else if (start) begin
            a0_q <= rq_addr_q[0];
            low_byte_strobe_q <= rq_wide_q ? rq_addr_q[0] : !rq_addr_q[0];
        end else if (second) begin
            a0_q <= !a0_q;
            low_byte_strobe_q <= a0_q;
        end
    end

    // Pin drivers, bus clock and chip select muxing
    always_ff @(posedge i_link_clk) begin
        if (lrst) begin
            bus_clock_out_q <= 1'h0;
            rw_oe_q <= 1'h0;
            low_byte_strobe_oe_q <= 1'h0;
            xport_out_q <= CS_IDLE;
            xport_oe_q <= 2'h0;
        end else begin
            bus_clock_out_q <= bus_clock_out_run && ph_q[BUS_CLOCK_OUT_BIT];
            rw_oe_q <= cfg_s[CFG_DIRECTION_PIN_ENABLE];
            low_byte_strobe_oe_q <= cfg_s[CFG_BYTE_STROBE_PIN_ENABLE];
            if (cs_role_s) begin
                xport_out_q <= {ecs_n_d, xcs_n_d};
                xport_oe_q <= 2'h3;
            end else begin
                xport_out_q <= cfg_s[CFG_GPIO_OUT+1:CFG_GPIO_OUT];
                xport_oe_q <= cfg_s[CFG_GPIO_OE+1:CFG_GPIO_OE];
            end
        end
    end

    assign o_rw = rw_q;
    assign o_rw_oe = rw_oe_q;
    assign o_low_byte_strobe_n = low_byte_strobe_q;
    assign o_low_byte_strobe_oe = low_byte_strobe_oe_q;
    assign o_addr_bit0 = a0_q;
    assign o_bus_clock_out = bus_clock_out_q;
    assign o_xport_out = xport_out_q;
    assign o_xport_oe = xport_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_rw_dir;
        @(posedge i_link_clk) disable iff (lrst)
        active |-> (rw_q == !cap_wr_q);
    endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("direction wrong in cycle");

    property p_rw_hold_low;
        @(posedge i_link_clk) disable iff (lrst)
        (!rw_q && !(start && !rq_wr_q)) |=> !rw_q;
    endproperty
    a_rw_hold_low: assert property (p_rw_hold_low) else $error("direction rose between writes");

    property p_low_byte_strobe_word;
        @(posedge i_link_clk) disable iff (lrst)
        (active && cap_wide_q) |-> (low_byte_strobe_q == a0_q);
    endproperty
    a_low_byte_strobe_word: assert property (p_low_byte_strobe_word) else $error("word strobe encoding wrong");

    property p_low_byte_strobe_byte;
        @(posedge i_link_clk) disable iff (lrst)
        (active && !cap_wide_q) |-> (low_byte_strobe_q != a0_q);
    endproperty
    a_low_byte_strobe_byte: assert property (p_low_byte_strobe_byte) else $error("byte strobe encoding wrong");

    property p_pin_enable;
        @(posedge i_link_clk) disable iff (lrst)
        ##1 (o_rw_oe == $past(cfg_s[CFG_DIRECTION_PIN_ENABLE])) && (o_low_byte_strobe_oe == $past(cfg_s[CFG_BYTE_STROBE_PIN_ENABLE]));
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin enable not followed");

    property p_cs_gap;
        @(posedge i_link_clk) disable iff (lrst)
        (active && gap && cs_role_s) |=> (o_xport_out == CS_IDLE);
    endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("select did not return high");

    property p_cs_exclusive;
        @(posedge i_link_clk) disable iff (lrst)
        cs_role_s |=> (o_xport_out != 2'h0);
    endproperty
    a_cs_exclusive: assert property (p_cs_exclusive) else $error("both selects low");

    property p_gpio_release;
        @(posedge i_link_clk) disable iff (lrst)
        !cs_role_s |=> (o_xport_oe == $past(cfg_s[CFG_GPIO_OE+1:CFG_GPIO_OE]));
    endproperty
    a_gpio_release: assert property (p_gpio_release) else $error("port not released to gpio");

    sequence s_split_first_end;
        cyc_end && cap_split_q && first_q;
    endsequence
    property p_split;
        @(posedge i_link_clk) disable iff (lrst)
        s_split_first_end |=> active [*4] ##1 (st_q == EBC_L_DONE);
    endproperty
    a_split: assert property (p_split) else $error("word not split into two bytes");

    property p_secure;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_mode_wr && i_secure) |=> (mode_q == $past(mode_q));
    endproperty
    a_secure: assert property (p_secure) else $error("mode changed while secure");

    property p_bdm_reset;
        @(posedge i_core_clk) disable iff (i_srst)
        $past(i_srst) |-> (o_bdm_active == special);
    endproperty
    a_bdm_reset: assert property (p_bdm_reset) else $error("debug state wrong after reset");

endmodule

//--- inc/ebc_pkg.sv
// Shared constants and types for the external bus control block
package ebc_pkg;

    // Operating mode codes, strap order {c, b, a}
    localparam logic [2:0] MODE_SPEC_SINGLE = 3'h0;
    localparam logic [2:0] MODE_EMU_NARROW = 3'h1;
    localparam logic [2:0] MODE_SPEC_TEST = 3'h2;
    localparam logic [2:0] MODE_EMU_WIDE = 3'h3;
    localparam logic [2:0] MODE_NORM_SINGLE = 3'h4;
    localparam logic [2:0] MODE_NORM_NARROW = 3'h5;
    localparam logic [2:0] MODE_PERIPH = 3'h6;
    localparam logic [2:0] MODE_NORM_WIDE = 3'h7;

    // Address map regions
    localparam logic [15:0] REG_LAST = 16'h03FF;
    localparam logic [15:0] RAM_BASE = 16'h1000;
    localparam logic [15:0] RAM_LAST = 16'h3FFF;
    localparam logic [15:0] FLASH_BASE = 16'h4000;

    // Bus cycle phases on the link clock
    localparam logic [1:0] PHASE_GAP = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam int BUS_CLOCK_OUT_BIT = 1;

    // Pin reset levels
    localparam logic PIN_HIGH = 1'h1;
    localparam logic [1:0] CS_IDLE = 2'h3;

    // Field positions in the configuration crossing vector
    localparam int CFG_W = 10;
    localparam int CFG_STR = 9;
    localparam int CFG_IVIS = 8;
    localparam int CFG_BUS_CLOCK_OUT_DIS = 7;
    localparam int CFG_DIRECTION_PIN_ENABLE = 6;
    localparam int CFG_BYTE_STROBE_PIN_ENABLE = 5;
    localparam int CFG_CS_ROLE = 4;
    localparam int CFG_GPIO_OUT = 2;
    localparam int CFG_GPIO_OE = 0;

    // Link side sequencer states
    typedef enum logic [2:0] {
        EBC_L_IDLE = 3'b001,
        EBC_L_CYC = 3'b010,
        EBC_L_DONE = 3'b100
    } ebc_link_e;

endpackage

//--- rtl/ebc_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module ebc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        meta_q <= i_d;
        sync_q <= meta_q;
    end

    assign o_q = sync_q;
endmodule

//--- rtl/ebc_mode_dec.sv
// Operating mode decoder
`timescale 1ns/1ps
module ebc_mode_dec
    import ebc_pkg::*;
(
    input wire logic [2:0] i_mode,
    output logic o_expanded,
    output logic o_narrow,
    output logic o_special_single
);
    // Expanded modes drive the bus; peripheral mode is kept off the bus
    assign o_expanded = (i_mode == MODE_EMU_NARROW) || (i_mode == MODE_SPEC_TEST) ||
                        (i_mode == MODE_EMU_WIDE) || (i_mode == MODE_NORM_NARROW) ||
                        (i_mode == MODE_NORM_WIDE);
    assign o_narrow = (i_mode == MODE_EMU_NARROW) || (i_mode == MODE_NORM_NARROW);
    assign o_special_single = (i_mode == MODE_SPEC_SINGLE);
endmodule

//--- tb/ebc_ext_sys.sv
// External side model: strap pull resistors and bus cycle recorder
`timescale 1ns/1ps
module ebc_ext_sys (
    input wire logic i_link_clk,
    input wire logic [2:0] i_pull,
    input wire logic [1:0] i_drv,
    input wire logic i_drv_oe,
    input wire logic [4:0] i_bus,
    input wire logic i_bus_clock_out,
    output logic [2:0] o_strap
);
    logic [4:0] cap [0:255];
    int cnt = 0;
    logic bus_clock_out_q = 1'h0;
    // Straps are only pulled, so the device drive wins once enabled
    assign o_strap = {i_pull[2], i_drv_oe ? i_drv : i_pull[1:0]};
    // One entry per bus clock rise: direction, strobe, a0, both selects
    always @(posedge i_link_clk) begin
        bus_clock_out_q <= i_bus_clock_out;
        if (i_bus_clock_out && !bus_clock_out_q) begin
            cap[cnt[7:0]] <= i_bus;
            cnt <= cnt + 1;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the external bus control block
`timescale 1ns/1ps
module tb_top;
    import ebc_pkg::*;
    logic i_core_clk = 1'h0, i_link_clk = 1'h0, i_srst = 1'h1, i_internal_flash_enable = 1'h0, i_secure = 1'h0;
    logic i_mode_wr = 1'h0, i_dbg_enable = 1'h0, i_dbg_activate = 1'h0, i_dbg_exit = 1'h0, i_req_valid = 1'h0;
    logic i_page_expand_enable = 1'h1, i_stretch_enable = 1'h1, i_int_visibility = 1'h0, i_bus_clock_out_disable = 1'h0;
    logic i_direction_pin_enable = 1'h1, i_byte_strobe_pin_enable = 1'h1, i_req_write = 1'h0, i_req_wide = 1'h0;
    logic [2:0] i_mode_wdata = 3'h0, pull = 3'h0, strap, o_mode;
    logic [1:0] i_xport_gpio_out = 2'h0, i_xport_gpio_oe = 2'h0, o_strap_pins_out, o_xport_out, o_xport_oe;
    logic [15:0] i_req_addr = 16'h0000;
    logic o_expanded, o_narrow, o_bdm_active, o_strap_pins_oe, o_req_ready, o_req_done, o_rw, o_rw_oe, x;
    logic o_low_byte_strobe_n, o_low_byte_strobe_oe, o_addr_bit0, o_bus_clock_out, last_wr = 1'h0, wr_run = 1'h0;
    logic [2:0] tm [5] = '{3'h7, 3'h5, 3'h3, 3'h1, 3'h2};
    logic [4:0] exq [$];
    int fails = 0, check_count = 0, cycles = 0, idx = 0, r;
    wire i_strap_a = strap[0], i_strap_b = strap[1], i_strap_c = strap[2];
    wire [1:0] i_strap_pins_out = pull[1:0];

    ebc_top dut (.i_core_clk, .i_srst, .i_link_clk, .i_strap_a, .i_strap_b, .i_strap_c, .i_internal_flash_enable,
        .i_secure, .i_mode_wr, .i_mode_wdata, .o_mode, .o_expanded, .o_narrow, .i_dbg_enable, .i_dbg_activate,
        .i_dbg_exit, .o_bdm_active, .i_page_expand_enable, .i_stretch_enable, .i_int_visibility, .i_bus_clock_out_disable,
        .i_direction_pin_enable, .i_byte_strobe_pin_enable, .i_xport_gpio_out, .i_xport_gpio_oe,
        .i_strap_pins_out, .o_strap_pins_out, .o_strap_pins_oe, .i_req_valid, .o_req_ready, .i_req_write,
        .i_req_wide, .i_req_addr, .o_req_done, .o_rw, .o_rw_oe, .o_low_byte_strobe_n, .o_low_byte_strobe_oe,
        .o_addr_bit0, .o_bus_clock_out, .o_xport_out, .o_xport_oe);
    ebc_ext_sys u_ext (.i_link_clk, .i_pull(pull), .i_drv(o_strap_pins_out), .i_drv_oe(o_strap_pins_oe),
        .i_bus({o_rw, o_low_byte_strobe_n, o_addr_bit0, o_xport_out}), .i_bus_clock_out(o_bus_clock_out), .o_strap(strap));

    // Core clock 50 ns, link clock 48 ns with its own phase
    initial forever #25 i_core_clk = ~i_core_clk;
    initial #6 forever #24 i_link_clk = ~i_link_clk;

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Reset with the given strap code on the pull resistors
    task automatic do_reset(input logic [2:0] code);
        pull <= code;
        i_srst <= 1'h1;
        repeat (8) @(posedge i_core_clk);
        i_srst <= 1'h0;
        repeat (6) @(posedge i_core_clk);
        last_wr = 1'h0;
    endtask

    // One-cycle pulse on mode write, exit, activate, enable
    task automatic pulse(input logic [3:0] sel);
        {i_mode_wr, i_dbg_exit, i_dbg_activate, i_dbg_enable} <= sel;
        @(posedge i_core_clk);
        {i_mode_wr, i_dbg_exit, i_dbg_activate, i_dbg_enable} <= 4'h0;
        repeat (3) @(posedge i_core_clk);
    endtask

    // Expected pins of one access: direction, strobe, a0, both selects
    task automatic expect_acc(input logic wr, input logic wd, input logic [15:0] ad);
        logic emulation_chip_select, external_chip_select;
        emulation_chip_select = ad >= FLASH_BASE && !i_internal_flash_enable;
        external_chip_select = ad > REG_LAST && ad < RAM_BASE;
        exq.push_back({~wr, wd ? ad[0] : ~ad[0], ad[0], ~emulation_chip_select, ~external_chip_select});
    endtask

    // Hand one request over, wait for completion, compare recorded cycles
    task automatic req(input logic wr, input logic wd, input logic [15:0] ad);
        int n;
        wr_run = last_wr && wr;
        if (o_narrow === 1'h1 && wd) begin
            expect_acc(wr, 1'h0, ad);
            expect_acc(wr, 1'h0, ad ^ 16'h0001);
        end else expect_acc(wr, wd, ad);
        i_req_valid <= 1'h1;
        i_req_write <= wr;
        i_req_wide <= wd;
        i_req_addr <= ad;
        n = 0;
        #1;
        while (o_req_ready !== 1'h1 && n < 50) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        @(posedge i_core_clk);
        i_req_valid <= 1'h0;
        n = 0;
        #1;
        while (o_req_done !== 1'h1 && n < 200) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        chk({15'h0, o_req_done}, 16'h0001);
        wr_run = 1'h0;
        last_wr = wr;
        @(posedge i_core_clk);
        while (idx < exq.size()) begin
            chk({11'h0, u_ext.cap[idx[7:0]]}, {11'h0, exq[idx]});
            idx++;
        end
        chk(u_ext.cnt[15:0], idx[15:0]);
    endtask

    // Direction stays low across back to back writes
    always @(posedge i_link_clk) begin
        if (wr_run && o_rw !== 1'h0) chk({15'h0, o_rw}, 16'h0000);
    end

    // Cycle ceiling cuts a hang short
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'hCC60);
        for (int c = 0; c < 8; c++) begin
            do_reset(c[2:0]);
            x = c inside {1, 2, 3, 5, 7};
            chk({13'h0, o_mode}, c[15:0]);
            chk({11'h0, o_expanded, o_narrow, o_bdm_active, o_strap_pins_oe, o_req_ready},
                {11'h0, x, c == 1 || c == 5, c == 0, x, x});
        end
        do_reset(MODE_NORM_SINGLE);
        pulse(4'h2);
        chk({15'h0, o_bdm_active}, 16'h0000);
        pulse(4'h1);
        pulse(4'h2);
        chk({15'h0, o_bdm_active}, 16'h0001);
        pulse(4'h4);
        chk({15'h0, o_bdm_active}, 16'h0000);
        i_secure <= 1'h1;
        i_mode_wdata <= MODE_NORM_WIDE;
        pulse(4'h8);
        chk({13'h0, o_mode}, {13'h0, MODE_NORM_SINGLE});
        i_secure <= 1'h0;
        pulse(4'h8);
        chk({13'h0, o_mode}, {13'h0, MODE_NORM_WIDE});
        for (int k = 0; k < 8; k++) begin
            r = $urandom;
            {i_page_expand_enable, i_direction_pin_enable, i_byte_strobe_pin_enable} <= k[2:0];
            {i_xport_gpio_out, i_xport_gpio_oe} <= r[3:0];
            repeat (6) @(posedge i_core_clk);
            chk({14'h0, o_rw_oe, o_low_byte_strobe_oe}, {14'h0, k[1:0]});
            if (k < 4) chk({12'h0, o_xport_out, o_xport_oe}, {12'h0, r[3:0]});
            else chk({12'h0, o_xport_out, o_xport_oe}, 16'h000F);
        end
        // Random traffic in each expanded mode, never with peripheral straps
        foreach (tm[m]) begin
            do_reset(tm[m]);
            for (int k = 0; k < 16; k++) begin
                r = $urandom;
                i_internal_flash_enable <= r[4];
                repeat (4) @(posedge i_core_clk);
                req(r[0] | r[5], r[1], r[3:2] == 2'h0 ? {4'h0, r[27:16]} : r[31:16]);
            end
        end
        // Strap pins carry the driven copy once expanded
        chk({14'h0, o_strap_pins_out}, {14'h0, pull[1:0]});
        // Bus clock idles low with stretch on, then free-runs with stretch off
        r = 0;
        repeat (8) begin
            @(posedge i_core_clk);
            r = r | (o_bus_clock_out ? 2 : 1);
        end
        chk(r[15:0], 16'h0001);
        i_stretch_enable <= 1'h0;
        repeat (6) @(posedge i_core_clk);
        r = 0;
        repeat (8) begin
            @(posedge i_core_clk);
            r = r | (o_bus_clock_out ? 2 : 1);
        end
        chk(r[15:0], 16'h0003);
        final_report();
    end
endmodule
